// ---- hdl/meabt_move_timer.sv ----
// move instruction sequencer: opcode fetch, operand reads, idle periods, writes
// assumes one 100 MHz clock, a 16-bit memory bus and a caller that starts one move at a time
`timescale 1ns/1ps
`default_nettype none
module meabt_move_timer (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // move request
    input wire logic start_in,
    input wire meabt_pkg::meabt_mode_type src_mode_in,
    input wire meabt_pkg::meabt_mode_type dst_mode_in,
    input wire logic long_in,
    // memory bus
    input wire logic mem_ready_in,
    output logic bus_read_out,
    output logic bus_write_out,
    output logic bus_idle_out,
    // status
    output logic busy_out,
    output logic done_out,
    // result of the last move
    output logic [15:0] total_clocks_out,
    output logic [2:0] read_cycles_out,
    output logic [1:0] write_cycles_out,
    output logic [2:0] idle_clocks_out,
    output logic [15:0] wait_clocks_out
);

    // ************************************************************
    // operand costs
    // ************************************************************
    logic [2:0] src_reads;
    logic [2:0] src_idle;
    logic [1:0] src_writes;
    logic [2:0] dst_reads;
    logic [2:0] dst_idle;
    logic [1:0] dst_writes;

    meabt_ea_calc u_src_cost (
        .mode_in(src_mode_in),
        .long_in(long_in),
        .dest_in(1'b0),
        .reads_out(src_reads),
        .idle_out(src_idle),
        .writes_out(src_writes)
    );

    meabt_ea_calc u_dst_cost (
        .mode_in(dst_mode_in),
        .long_in(long_in),
        .dest_in(1'b1),
        .reads_out(dst_reads),
        .idle_out(dst_idle),
        .writes_out(dst_writes)
    );

    // ************************************************************
    // bus cycle engine
    // ************************************************************
    logic bus_req;
    logic bus_req_write;
    logic bus_active;
    logic cycle_done;
    logic wait_state;

    meabt_bus_cycle u_bus (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .req_in(bus_req),
        .write_in(bus_req_write),
        .mem_ready_in(mem_ready_in),
        .bus_read_out(bus_read_out),
        .bus_write_out(bus_write_out),
        .active_out(bus_active),
        .cycle_done_out(cycle_done),
        .wait_state_out(wait_state)
    );

    // ************************************************************
    // sequencer state
    // ************************************************************
    meabt_pkg::meabt_state_type state_r;
    meabt_pkg::meabt_state_type state_nxt;
    logic [2:0] rd_left_r;
    logic [2:0] idle_left_r;
    logic [1:0] wr_left_r;
    meabt_pkg::meabt_mode_type src_mode_r;
    meabt_pkg::meabt_mode_type dst_mode_r;
    logic long_r;
    logic rd_last;
    logic wr_last;
    logic idle_last;
    logic go_write;

    assign rd_last = (rd_left_r == meabt_pkg::STEP3);
    assign wr_last = (wr_left_r == meabt_pkg::STEP2);
    assign idle_last = (idle_left_r == meabt_pkg::STEP3);
    assign go_write = (wr_left_r != meabt_pkg::WR_NONE);

    always_comb begin
        state_nxt = state_r;
        bus_req = 1'b0;
        bus_req_write = 1'b0;
        unique case (state_r)
            meabt_pkg::ST_IDLE: begin
                if (start_in) begin
                    state_nxt = meabt_pkg::ST_READ;
                end
            end
            meabt_pkg::ST_READ: begin
                // chain the next cycle in the done period so no dead period appears
                bus_req = !(cycle_done && rd_last) ||
                    (idle_left_r == meabt_pkg::IDLE_NONE && go_write);
                bus_req_write = cycle_done && rd_last;
                if (cycle_done && rd_last) begin
                    if (idle_left_r != meabt_pkg::IDLE_NONE) begin
                        state_nxt = meabt_pkg::ST_INTERNAL;
                    end else if (go_write) begin
                        state_nxt = meabt_pkg::ST_WRITE;
                    end else begin
                        state_nxt = meabt_pkg::ST_FINISH;
                    end
                end
            end
            meabt_pkg::ST_INTERNAL: begin
                bus_req = idle_last && go_write;
                bus_req_write = 1'b1;
                if (idle_last) begin
                    state_nxt = go_write ? meabt_pkg::ST_WRITE : meabt_pkg::ST_FINISH;
                end
            end
            meabt_pkg::ST_WRITE: begin
                bus_req = !(cycle_done && wr_last);
                bus_req_write = 1'b1;
                if (cycle_done && wr_last) begin
                    state_nxt = meabt_pkg::ST_FINISH;
                end
            end
            meabt_pkg::ST_FINISH: begin
                state_nxt = meabt_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = meabt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= meabt_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // work left in this move
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_left_r <= meabt_pkg::EXT_NONE;
            idle_left_r <= meabt_pkg::IDLE_NONE;
            wr_left_r <= meabt_pkg::WR_NONE;
        end else if (state_r == meabt_pkg::ST_IDLE && start_in) begin
            // opcode fetch always leads, so a move is never free
            rd_left_r <= meabt_pkg::FETCH_READS + src_reads + dst_reads;
            idle_left_r <= src_idle + dst_idle;
            wr_left_r <= src_writes + dst_writes;
        end else begin
            if (state_r == meabt_pkg::ST_READ && cycle_done) begin
                rd_left_r <= rd_left_r - meabt_pkg::STEP3;
            end
            if (state_r == meabt_pkg::ST_INTERNAL) begin
                idle_left_r <= idle_left_r - meabt_pkg::STEP3;
            end
            if (state_r == meabt_pkg::ST_WRITE && cycle_done) begin
                wr_left_r <= wr_left_r - meabt_pkg::STEP2;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            src_mode_r <= meabt_pkg::MODE_DATA_REG;
            dst_mode_r <= meabt_pkg::MODE_DATA_REG;
            long_r <= 1'b0;
        end else if (state_r == meabt_pkg::ST_IDLE && start_in) begin
            src_mode_r <= src_mode_in;
            dst_mode_r <= dst_mode_in;
            long_r <= long_in;
        end
    end

    // ************************************************************
    // clock accounting
    // ************************************************************
    logic [15:0] total_r;
    logic [15:0] wait_r;
    logic [2:0] rd_cnt_r;
    logic [1:0] wr_cnt_r;
    logic [2:0] idle_cnt_r;
    logic tick;

    // every period in a bus cycle or in internal work is one external clock period
    assign tick = bus_active || state_r == meabt_pkg::ST_INTERNAL;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            total_r <= meabt_pkg::ZERO16;
            wait_r <= meabt_pkg::ZERO16;
            rd_cnt_r <= meabt_pkg::EXT_NONE;
            wr_cnt_r <= meabt_pkg::WR_NONE;
            idle_cnt_r <= meabt_pkg::IDLE_NONE;
        end else if (state_r == meabt_pkg::ST_IDLE && start_in) begin
            total_r <= meabt_pkg::ZERO16;
            wait_r <= meabt_pkg::ZERO16;
            rd_cnt_r <= meabt_pkg::EXT_NONE;
            wr_cnt_r <= meabt_pkg::WR_NONE;
            idle_cnt_r <= meabt_pkg::IDLE_NONE;
        end else begin
            if (tick) begin
                total_r <= total_r + meabt_pkg::STEP16;
            end
            if (wait_state) begin
                wait_r <= wait_r + meabt_pkg::STEP16;
            end
            if (cycle_done && state_r == meabt_pkg::ST_READ) begin
                rd_cnt_r <= rd_cnt_r + meabt_pkg::STEP3;
            end
            if (cycle_done && state_r == meabt_pkg::ST_WRITE) begin
                wr_cnt_r <= wr_cnt_r + meabt_pkg::STEP2;
            end
            if (state_r == meabt_pkg::ST_INTERNAL) begin
                idle_cnt_r <= idle_cnt_r + meabt_pkg::STEP3;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign bus_idle_out = (state_r == meabt_pkg::ST_INTERNAL);
    assign busy_out = (state_r != meabt_pkg::ST_IDLE);
    assign done_out = (state_r == meabt_pkg::ST_FINISH);
    assign total_clocks_out = total_r;
    assign wait_clocks_out = wait_r;
    assign read_cycles_out = rd_cnt_r;
    assign write_cycles_out = wr_cnt_r;
    assign idle_clocks_out = idle_cnt_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    logic [15:0] expect_total;
    assign expect_total = 16'({13'h0000, rd_cnt_r} + {14'h0000, wr_cnt_r}) * 16'h0004
        + {13'h0000, idle_cnt_r} + wait_r;

    sequence s_move_done_clean;
        done_out && wait_r == 16'h0000;
    endsequence

    a_total_consistent: assert property (done_out |-> total_r == expect_total)
        else $error("total clocks disagree with bus cycles and idle periods");
    a_no_write_in_ea: assert property (state_r == meabt_pkg::ST_READ && !cycle_done
        |-> !bus_req_write)
        else $error("write requested during operand address phase");
    a_idle_no_bus: assert property (bus_idle_out |-> !bus_active)
        else $error("bus busy during an idle period");
    a_fetch_counted: assert property (done_out |-> rd_cnt_r >= 3'h1)
        else $error("move finished without an opcode fetch");
    a_reg_reg_move: assert property (s_move_done_clean and (src_mode_r == meabt_pkg::MODE_DATA_REG
        && dst_mode_r == meabt_pkg::MODE_DATA_REG) |-> total_r == 16'h0004
        && rd_cnt_r == 3'h1 && wr_cnt_r == 2'h0)
        else $error("register to register move not four clocks one read");
    a_long_reg_ind: assert property (s_move_done_clean and (long_r
        && src_mode_r == meabt_pkg::MODE_DATA_REG && dst_mode_r == meabt_pkg::MODE_IND)
        |-> total_r == 16'h000c && rd_cnt_r == 3'h1 && wr_cnt_r == 2'h2)
        else $error("long register to indirect move not twelve clocks");
    a_abs_long_move: assert property (s_move_done_clean and (long_r
        && src_mode_r == meabt_pkg::MODE_ABS_LONG && dst_mode_r == meabt_pkg::MODE_ABS_LONG)
        |-> total_r == 16'h0024 && rd_cnt_r == 3'h7 && wr_cnt_r == 2'h2)
        else $error("long absolute move not thirty six clocks");
    a_predec_idle: assert property (done_out && src_mode_r == meabt_pkg::MODE_PREDEC
        && dst_mode_r == meabt_pkg::MODE_DATA_REG |-> idle_cnt_r == 3'h2)
        else $error("predecrement source lacks two idle clocks");
    a_reg_dest_no_write: assert property (done_out && dst_mode_r == meabt_pkg::MODE_ADDR_REG
        |-> wr_cnt_r == 2'h0)
        else $error("register destination produced a write");
    a_finish_pulse: assert property (done_out |=> !done_out && !busy_out)
        else $error("done not a single cycle");
endmodule : meabt_move_timer
`default_nettype wire

// ---- hdl/meabt_pkg.sv ----
// constants, operand mode codes and bus timing figures for the move timing sequencer
// assumes one 100 MHz clock and a 16-bit memory bus with four-period cycles
package meabt_pkg;

    // ************************************************************
    // bus cycle timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [2:0] BUS_PERIODS = 3'h4;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_STEP = 2'h1;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // ************************************************************
    // effective address costs
    // ************************************************************
    localparam logic [2:0] EXT_NONE = 3'h0;
    localparam logic [2:0] EXT_SHORT = 3'h1;
    localparam logic [2:0] EXT_LONG = 3'h2;
    localparam logic [2:0] OPER_BW = 3'h1;
    localparam logic [2:0] OPER_LONG = 3'h2;
    localparam logic [2:0] IDLE_NONE = 3'h0;
    localparam logic [2:0] IDLE_PREDEC = 3'h2;
    localparam logic [2:0] IDLE_INDEX = 3'h2;
    localparam logic [1:0] WR_NONE = 2'h0;
    localparam logic [1:0] WR_BW = 2'h1;
    localparam logic [1:0] WR_LONG = 2'h2;
    localparam logic [2:0] FETCH_READS = 3'h1;

    // ************************************************************
    // counter steps and widths
    // ************************************************************
    localparam int CNT_W = 16;
    localparam logic [2:0] STEP3 = 3'h1;
    localparam logic [1:0] STEP2 = 2'h1;
    localparam logic [CNT_W-1:0] STEP16 = 16'h0001;
    localparam logic [CNT_W-1:0] ZERO16 = 16'h0000;

    // ************************************************************
    // operand addressing modes
    // ************************************************************
    typedef enum logic [3:0] {
        MODE_DATA_REG = 4'h0,
        MODE_ADDR_REG = 4'h1,
        MODE_IND = 4'h2,
        MODE_POSTINC = 4'h3,
        MODE_PREDEC = 4'h4,
        MODE_DISP16 = 4'h5,
        MODE_INDEX = 4'h6,
        MODE_ABS_SHORT = 4'h7,
        MODE_ABS_LONG = 4'h8,
        MODE_PC_DISP = 4'h9,
        MODE_PC_INDEX = 4'ha,
        MODE_IMMED = 4'hb
    } meabt_mode_type;

    // ************************************************************
    // sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_INTERNAL = 3'b010,
        ST_WRITE = 3'b011,
        ST_FINISH = 3'b100
    } meabt_state_type;

endpackage : meabt_pkg

// ---- hdl/meabt_ea_calc.sv ----
// cost of one operand: bus reads, internal idle periods and writes
// assumes a move where the source is read and the destination written
`timescale 1ns/1ps
`default_nettype none
module meabt_ea_calc (
    // operand
    input wire meabt_pkg::meabt_mode_type mode_in,
    input wire logic long_in,
    input wire logic dest_in,
    // cost
    output logic [2:0] reads_out,
    output logic [2:0] idle_out,
    output logic [1:0] writes_out
);
    logic [2:0] oper;
    logic [1:0] mem_wr;

    always_comb begin
        // a destination is stored, never fetched; computing its address writes nothing
        oper = dest_in ? meabt_pkg::EXT_NONE :
            (long_in ? meabt_pkg::OPER_LONG : meabt_pkg::OPER_BW);
        mem_wr = !dest_in ? meabt_pkg::WR_NONE :
            (long_in ? meabt_pkg::WR_LONG : meabt_pkg::WR_BW);
        reads_out = meabt_pkg::EXT_NONE;
        idle_out = meabt_pkg::IDLE_NONE;
        writes_out = meabt_pkg::WR_NONE;
        unique case (mode_in)
            meabt_pkg::MODE_DATA_REG, meabt_pkg::MODE_ADDR_REG: begin
                reads_out = meabt_pkg::EXT_NONE;
            end
            meabt_pkg::MODE_IND, meabt_pkg::MODE_POSTINC: begin
                reads_out = oper;
                writes_out = mem_wr;
            end
            meabt_pkg::MODE_PREDEC: begin
                reads_out = oper;
                idle_out = dest_in ? meabt_pkg::IDLE_NONE : meabt_pkg::IDLE_PREDEC;
                writes_out = mem_wr;
            end
            meabt_pkg::MODE_DISP16, meabt_pkg::MODE_ABS_SHORT: begin
                reads_out = meabt_pkg::EXT_SHORT + oper;
                writes_out = mem_wr;
            end
            meabt_pkg::MODE_INDEX: begin
                // index width is not an input: it never changes the cost
                reads_out = meabt_pkg::EXT_SHORT + oper;
                idle_out = meabt_pkg::IDLE_INDEX;
                writes_out = mem_wr;
            end
            meabt_pkg::MODE_ABS_LONG: begin
                reads_out = meabt_pkg::EXT_LONG + oper;
                writes_out = mem_wr;
            end
            meabt_pkg::MODE_PC_DISP: begin
                reads_out = dest_in ? meabt_pkg::EXT_NONE :
                    meabt_pkg::EXT_SHORT + oper;
            end
            meabt_pkg::MODE_PC_INDEX: begin
                reads_out = dest_in ? meabt_pkg::EXT_NONE :
                    meabt_pkg::EXT_SHORT + oper;
                idle_out = dest_in ? meabt_pkg::IDLE_NONE : meabt_pkg::IDLE_INDEX;
            end
            meabt_pkg::MODE_IMMED: begin
                // operand comes from the instruction stream
                reads_out = oper;
            end
            default: begin
                reads_out = meabt_pkg::EXT_NONE;
            end
        endcase
    end
endmodule : meabt_ea_calc
`default_nettype wire

// ---- hdl/meabt_bus_cycle.sv ----
// one memory read or write cycle of four periods, stretched by wait states
// assumes memory raises mem_ready_in in the last period when it can finish
`timescale 1ns/1ps
`default_nettype none
module meabt_bus_cycle (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // request
    input wire logic req_in,
    input wire logic write_in,
    // memory
    input wire logic mem_ready_in,
    output logic bus_read_out,
    output logic bus_write_out,
    // status
    output logic active_out,
    output logic cycle_done_out,
    output logic wait_state_out
);
    logic active_r;
    logic write_r;
    logic [1:0] phase_r;
    logic start;

    assign cycle_done_out = active_r && (phase_r == meabt_pkg::PHASE_LAST) && mem_ready_in;
    // a slow memory holds the last period; each held period is a wait state
    assign wait_state_out = active_r && (phase_r == meabt_pkg::PHASE_LAST)
        && !mem_ready_in;
    assign start = req_in && (!active_r || cycle_done_out);
    assign active_out = active_r;
    assign bus_read_out = active_r && !write_r;
    assign bus_write_out = active_r && write_r;

    // ************************************************************
    // cycle phase
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_r <= 1'b0;
            write_r <= 1'b0;
            phase_r <= meabt_pkg::PHASE_FIRST;
        end else if (start) begin
            active_r <= 1'b1;
            write_r <= write_in;
            phase_r <= meabt_pkg::PHASE_FIRST;
        end else if (cycle_done_out) begin
            active_r <= 1'b0;
        end else if (active_r && phase_r != meabt_pkg::PHASE_LAST) begin
            phase_r <= phase_r + meabt_pkg::PHASE_STEP;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_four_phases;
        phase_r == 2'h0 ##1 phase_r == 2'h1 ##1 phase_r == 2'h2 ##1 phase_r == 2'h3;
    endsequence

    a_phase_walk: assert property (start |=> s_four_phases)
        else $error("bus cycle phases out of order");
    a_four_periods: assert property ((start ##4 mem_ready_in) |-> cycle_done_out)
        else $error("zero wait cycle did not end in four periods");
    a_wait_holds: assert property (wait_state_out |=> active_r && phase_r == 2'h3)
        else $error("wait state did not hold the last period");
endmodule : meabt_bus_cycle
`default_nettype wire

// ---- testbench/meabt_mem_model.sv ----
// memory model: answers each bus cycle with ready, at once or after random waits
// assumes four-period cycles that repeat the last period while ready is low
`timescale 1ns/1ps
`default_nettype none
module meabt_mem_model (
    // bus
    input wire logic ref_clk_in,
    input wire logic bus_read_in,
    input wire logic bus_write_in,
    input wire logic slow_in,
    output logic mem_ready_out,
    output int waits_out,
    output int wr_done_out
);
    logic [1:0] ph_r = 2'h0;
    int seed = 5;
    initial begin
        mem_ready_out = 1'b1;
        waits_out = 0;
        wr_done_out = 0;
    end
    // ready wanders outside the last period, so early sampling shows up
    always @(posedge ref_clk_in) begin
        if (bus_read_in | bus_write_in) begin
            if (ph_r != 2'h3) begin
                ph_r <= ph_r + 2'h1;
            end else if (mem_ready_out) begin
                ph_r <= 2'h0;
                if (bus_write_in) wr_done_out <= wr_done_out + 1;
            end else begin
                waits_out <= waits_out + 1;
            end
        end else begin
            ph_r <= 2'h0;
        end
        #1 mem_ready_out <= slow_in ? 1'($random(seed)) : 1'b1;
    end
endmodule : meabt_mem_model
`default_nettype wire

// ---- testbench/tb.sv ----
// testbench: every source and destination mode, both sizes, fast and slow memory
// assumes the move timer and the memory model as the only parts
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ************************************************************
    // signals
    // ************************************************************
    localparam logic [2:0] RBW [12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    logic long_in = 1'b0;
    logic slow = 1'b0;
    meabt_pkg::meabt_mode_type src_mode_in = meabt_pkg::MODE_DATA_REG;
    meabt_pkg::meabt_mode_type dst_mode_in = meabt_pkg::MODE_DATA_REG;
    logic mem_ready, bus_read, bus_write, bus_idle, busy, done;
    logic [15:0] total, wait_clk;
    logic [2:0] rd, idl;
    logic [1:0] wr;
    logic [7:0] e;
    logic [7:0] exp_q [$];
    int err_total = 0, comparisons = 0, seed = 5, waits, w_prev = 0, idle_seen = 0;
    int busp = 0, wd_prev = 0, wr_done, ex;
    always #5 ref_clk_in = ~ref_clk_in;
    meabt_move_timer dut_u (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .start_in(start_in), .src_mode_in(src_mode_in), .dst_mode_in(dst_mode_in),
        .long_in(long_in), .mem_ready_in(mem_ready), .bus_read_out(bus_read),
        .bus_write_out(bus_write), .bus_idle_out(bus_idle), .busy_out(busy),
        .done_out(done), .total_clocks_out(total), .read_cycles_out(rd),
        .write_cycles_out(wr), .idle_clocks_out(idl), .wait_clocks_out(wait_clk));
    meabt_mem_model mem_u (.ref_clk_in(ref_clk_in), .bus_read_in(bus_read),
        .bus_write_in(bus_write), .slow_in(slow), .mem_ready_out(mem_ready),
        .waits_out(waits), .wr_done_out(wr_done));
    // ************************************************************
    // expectations and checks
    // ************************************************************
    function automatic logic [7:0] cost(input logic [3:0] s, input logic [3:0] d,
                                        input logic l);
        logic [2:0] r;
        logic [1:0] w;
        logic [2:0] i;
        r = 3'h1 + ((s < 4'hc) ? RBW[s] + 3'((RBW[s] != 3'h0) & l) : 3'h0);
        i = ((s == 4'h4 || s == 4'h6 || s == 4'ha) ? 3'h2 : 3'h0) + ((d == 4'h6) ? 3'h2 : 3'h0);
        w = 2'h0;
        if (d >= 4'h2 && d <= 4'h8) begin
            r = r + RBW[d] - 3'h1;
            w = l ? 2'h2 : 2'h1;
        end
        return {r, w, i};
    endfunction : cost
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        comparisons++;
        if (seen !== expv) begin
            err_total++;
            $display("wrong value at %0t: got %0d expected %0d", $time, seen, expv);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // sampled on the falling edge so register updates have landed
    always @(negedge ref_clk_in) begin
        if (bus_idle === 1'b1) idle_seen++;
        if ((bus_read | bus_write) === 1'b1) busp++;
        if (done === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hff;
            ex = 4 * (e[7:5] + e[4:3]) + waits - w_prev;
            check(16'(rd), 16'(e[7:5]));
            check(16'(wr), 16'(e[4:3]));
            check(16'(idl), 16'(e[2:0]));
            check(16'(idle_seen), 16'(e[2:0]));
            check(wait_clk, 16'(waits - w_prev));
            check(16'(busp), 16'(ex));
            check(16'(wr_done - wd_prev), 16'(e[4:3]));
            check(total, 16'(ex + e[2:0]));
            w_prev = waits;
            wd_prev = wr_done;
            idle_seen = 0;
            busp = 0;
        end
    end
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        repeat (2) @(posedge ref_clk_in);
        #1 reset_n_in = 1'b1;
        for (int k = 0; k < 288; k++) begin
            start_in = 1'b1;
            src_mode_in = meabt_pkg::meabt_mode_type'(k % 12);
            dst_mode_in = meabt_pkg::meabt_mode_type'((k / 12) % 12);
            long_in = 1'(k / 144);
            slow = 1'($random(seed));
            exp_q.push_back(cost(src_mode_in, dst_mode_in, long_in));
            @(posedge ref_clk_in);
            #1 start_in = 1'b0;
            @(posedge ref_clk_in);
            // a start while busy must be ignored
            #1 start_in = 1'($random(seed));
            src_mode_in = meabt_pkg::meabt_mode_type'($unsigned($random(seed)) % 12);
            @(posedge ref_clk_in);
            #1 start_in = 1'b0;
            // look off the edge so busy is settled when tested
            while (busy !== 1'b0) begin
                @(posedge ref_clk_in);
                #1;
            end
        end
        repeat (4) @(posedge ref_clk_in);
        check(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
